// ### src/pmcc_pkg.sv
package pmcc_pkg;

    // register bus geometry
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [2:0] OFS_POWER_CONTROL_0 = 3'h0;
    localparam logic [2:0] OFS_POWER_CONTROL_1 = 3'h1;
    localparam logic [2:0] OFS_REGULATOR_CTRL  = 3'h2;
    localparam logic [2:0] OFS_CLOCK_SELECT    = 3'h3;
    localparam logic [2:0] OFS_PERIPH_CLK_EN   = 3'h4;
    localparam logic [2:0] OFS_MODE_STATUS     = 3'h5;

    // field positions
    localparam int BIT_IDLE          = 0;   // power_control_0: core halt
    localparam int BIT_HALT          = 1;   // power_control_0: stop / shutdown
    localparam int BIT_FAST_WAKE     = 0;   // power_control_1: suspend
    localparam int BIT_LOW_SLEEP     = 1;   // power_control_1: snooze
    localparam int BIT_POWER_OFF_SEL = 0;   // regulator_control
    localparam int CLK_SRC_LSB       = 0;   // clock_select source, 2 bits
    localparam int CLK_DIV_LSB       = 2;   // clock_select divider code, 3 bits
    localparam int CLK_PRE_BIT       = 5;   // clock_select 1.5x pre-scaler

    // reset values: fast_osc_a divided by 8
    localparam logic [7:0] RST_CLOCK_SELECT  = 8'h0c;
    localparam logic [7:0] RST_PERIPH_CLK_EN = 8'h00;
    localparam logic [7:0] RST_ZERO          = 8'h00;

    // clock sources
    localparam logic [1:0] SRC_FAST_OSC_A = 2'h0;   // 24.5 MHz
    localparam logic [1:0] SRC_FAST_OSC_B = 2'h1;   // 49 MHz
    localparam logic [1:0] SRC_SLOW_OSC   = 2'h2;   // 80 kHz
    localparam logic [1:0] SRC_EXTERNAL   = 2'h3;

    // divider accumulator: step 2 per cycle, threshold 2 or 3 shifted by code
    localparam int         ACC_W    = 10;
    localparam logic [9:0] ACC_STEP = 10'h002;
    localparam logic [9:0] THR_PLAIN = 10'h002;
    localparam logic [9:0] THR_PRE   = 10'h003;

    // wake sources
    localparam int N_WAKE    = 6;
    localparam int W_TIMER4  = 0;
    localparam int W_SPI     = 1;
    localparam int W_TWI     = 2;
    localparam int W_PORT    = 3;
    localparam int W_CMP0    = 4;
    localparam int W_LOGIC   = 5;
    localparam int N_PERIPH  = 8;

    typedef enum logic [2:0] {
        PM_NORMAL,
        PM_IDLE,
        PM_SUSPEND,
        PM_STOP,
        PM_SNOOZE,
        PM_SHUTDOWN
    } pmcc_mode_t;

    typedef struct packed {
        logic       pre;
        logic [2:0] div;
        logic [1:0] src;
    } pmcc_clk_cfg_t;

    typedef struct packed {
        logic core_clk_en;
        logic fast_osc_a_en;
        logic fast_osc_b_en;
        logic slow_osc_en;
        logic reg_low_bias;
        logic power_nets_off;
        logic pin_hold;
        logic timer_slow_clk;
    } pmcc_pwr_t;

endpackage

// ### src/pmcc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pmcc_sync
    import pmcc_pkg::*;
#(
    parameter int W = 8
)
(
    input  wire logic         CLK,
    input  wire logic         RESET,
    input  wire logic [W-1:0] D,
    output var  logic [W-1:0] Q
);

    // two flops per bit; only the second stage is visible outside
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic stage1;
            logic stage2;
            always_ff @(posedge CLK)
            begin
                if (RESET)
                begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end
                else
                begin
                    stage1 <= D[i];
                    stage2 <= stage1;
                end
            end
            assign Q[i] = stage2;
        end
    endgenerate

endmodule
`default_nettype wire

// ### src/pmcc_clkdiv.sv
`timescale 1ns/1ns
`default_nettype none
module pmcc_clkdiv
    import pmcc_pkg::*;
(
    input  wire logic          CLK,
    input  wire logic          RESET,
    input  wire logic          RUN,
    input  wire pmcc_clk_cfg_t CFG,
    output var  logic          TICK
);

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic             next_tick;
    logic [ACC_W-1:0] thr;
    logic [ACC_W-1:0] sum;
    logic             fast_src;

    // fractional accumulator gives the 1.5x step without a second clock
    always_comb
    begin
        fast_src  = (CFG.src == SRC_FAST_OSC_A) || (CFG.src == SRC_FAST_OSC_B);
        thr       = ((CFG.pre && fast_src) ? THR_PRE : THR_PLAIN) << CFG.div;
        sum       = acc + ACC_STEP;
        next_acc  = acc;
        next_tick = 1'b0;
        if (RUN)
        begin
            if (sum >= thr)
            begin
                // a stale phase above a shrunken threshold restarts the period,
                // rather than bursting ticks until it drains
                next_acc  = (acc >= thr) ? '0 : sum - thr;
                next_tick = 1'b1;
            end
            else
            begin
                next_acc = sum;
            end
        end
    end

    // a halted clock freezes the phase so wake resumes mid-period
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            acc  <= '0;
            TICK <= 1'b0;
        end
        else
        begin
            acc  <= next_acc;
            TICK <= next_tick;
        end
    end

endmodule
`default_nettype wire

// ### src/pmcc_top.sv
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pmcc_top
    import pmcc_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                RESET,
    input  wire logic [ADDR_W-1:0]   ADDR,
    input  wire logic [DATA_W-1:0]   WDATA,
    input  wire logic                WR,
    input  wire logic                RD,
    output var  logic [DATA_W-1:0]   RDATA,
    input  wire logic                IRQ_PENDING,
    input  wire logic [N_WAKE-1:0]   WAKE_IN,
    input  wire logic                RESET_PIN_LOW,
    input  wire logic                RESET_SOURCE,
    output var  pmcc_pwr_t           PWR,
    output var  logic [N_PERIPH-1:0] PERIPH_CLK_EN,
    output var  pmcc_clk_cfg_t       CLK_CFG,
    output logic                     SYSTEM_CLOCK_TICK,
    output var  pmcc_mode_t          MODE
);

    localparam int N_SYNC = N_WAKE + 2;

    // synchronised pins
    logic [N_SYNC-1:0] sync_in;
    logic [N_SYNC-1:0] sync_out;
    logic              pin_rst;
    logic              src_rst;
    logic              sys_rst;
    logic [N_WAKE-1:0] wake_lvl;
    logic              cmp_prev;
    logic              cmp_fall;
    logic              wake_any;

    // register file
    logic [1:0]          power_control_0;
    logic [1:0]          power_control_1;
    logic                regulator_control;
    pmcc_clk_cfg_t       clock_select;
    logic [N_PERIPH-1:0] periph_en;
    logic [1:0]          next_power_control_0;
    logic [1:0]          next_power_control_1;
    logic                next_regulator_control;
    pmcc_clk_cfg_t       next_clock_select;
    logic [N_PERIPH-1:0] next_periph_en;
    logic [DATA_W-1:0]   next_rdata;

    // mode and outputs
    pmcc_mode_t          mode;
    pmcc_mode_t          next_mode;
    pmcc_pwr_t           next_pwr;
    logic [N_PERIPH-1:0] next_periph_clk;
    logic                wr_ok;

    // the pin is inverted ahead of the flops so their cleared state reads as released;
    // otherwise every power-on release would be followed by a false pin reset
    assign sync_in = {RESET_SOURCE, ~RESET_PIN_LOW, WAKE_IN};

    pmcc_sync #(
        .W     (N_SYNC)
    ) pmcc_sync_i (
        .CLK   (CLK),
        .RESET (RESET),
        .D     (sync_in),
        .Q     (sync_out)
    );

    assign wake_lvl = sync_out[N_WAKE-1:0];
    assign pin_rst  = sync_out[N_WAKE];
    assign src_rst  = sync_out[N_WAKE+1];

    // shutdown ignores every reset source except the pin and power-on
    assign sys_rst = RESET | pin_rst | (src_rst & (mode != PM_SHUTDOWN));

    // comparator wake is the falling edge, taken from the synchronised level
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            cmp_prev <= 1'b0;
        end
        else
        begin
            cmp_prev <= wake_lvl[W_CMP0];
        end
    end

    assign cmp_fall = cmp_prev & ~wake_lvl[W_CMP0];
    assign wake_any = wake_lvl[W_TIMER4] | wake_lvl[W_SPI] | wake_lvl[W_TWI]
                    | wake_lvl[W_PORT] | cmp_fall | wake_lvl[W_LOGIC];

    // writes only land while the core runs; a halted core cannot issue them
    assign wr_ok = WR && (mode == PM_NORMAL);

    // mode sequencing
    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            PM_NORMAL:
            begin
                // halt beats idle, fast-wake beats low-energy on a mixed write
                if (wr_ok && ADDR == OFS_POWER_CONTROL_0 && WDATA[BIT_HALT])
                begin
                    next_mode = regulator_control ? PM_SHUTDOWN : PM_STOP;
                end
                else if (wr_ok && ADDR == OFS_POWER_CONTROL_0 && WDATA[BIT_IDLE])
                begin
                    next_mode = PM_IDLE;
                end
                else if (wr_ok && ADDR == OFS_POWER_CONTROL_1 && WDATA[BIT_FAST_WAKE])
                begin
                    next_mode = PM_SUSPEND;
                end
                else if (wr_ok && ADDR == OFS_POWER_CONTROL_1 && WDATA[BIT_LOW_SLEEP])
                begin
                    next_mode = PM_SNOOZE;
                end
            end
            PM_IDLE:
            begin
                if (IRQ_PENDING)
                begin
                    next_mode = PM_NORMAL;
                end
            end
            PM_SUSPEND, PM_SNOOZE:
            begin
                if (wake_any)
                begin
                    next_mode = PM_NORMAL;
                end
            end
            PM_STOP, PM_SHUTDOWN:
            begin
                next_mode = mode; // left only through sys_rst
            end
        endcase
    end

    // register file next values
    always_comb
    begin
        next_power_control_0   = power_control_0;
        next_power_control_1   = power_control_1;
        next_regulator_control = regulator_control;
        next_clock_select      = clock_select;
        next_periph_en         = periph_en;
        if (wr_ok)
        begin
            unique case (ADDR)
                OFS_POWER_CONTROL_0: next_power_control_0   = WDATA[1:0];
                OFS_POWER_CONTROL_1: next_power_control_1   = WDATA[1:0];
                OFS_REGULATOR_CTRL:  next_regulator_control = WDATA[BIT_POWER_OFF_SEL];
                OFS_CLOCK_SELECT:    next_clock_select      = WDATA[5:0];
                OFS_PERIPH_CLK_EN:   next_periph_en         = WDATA;
                default:             next_periph_en         = periph_en;
            endcase
        end
        // the entry bit drops as the mode is left, so software need not clear it
        if (mode == PM_IDLE && next_mode == PM_NORMAL)
        begin
            next_power_control_0[BIT_IDLE] = 1'b0;
        end
        if ((mode == PM_SUSPEND || mode == PM_SNOOZE) && next_mode == PM_NORMAL)
        begin
            next_power_control_1 = 2'b00;
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_comb
    begin
        next_rdata = RST_ZERO;
        if (RD)
        begin
            unique case (ADDR)
                OFS_POWER_CONTROL_0: next_rdata = {6'h00, power_control_0};
                OFS_POWER_CONTROL_1: next_rdata = {6'h00, power_control_1};
                OFS_REGULATOR_CTRL:  next_rdata = {7'h00, regulator_control};
                OFS_CLOCK_SELECT:    next_rdata = {2'h0, clock_select};
                OFS_PERIPH_CLK_EN:   next_rdata = periph_en;
                OFS_MODE_STATUS:     next_rdata = {5'h00, mode};
                default:             next_rdata = RST_ZERO;
            endcase
        end
    end

    // power and clock controls follow the next mode so they switch with it
    always_comb
    begin
        next_pwr = '0;
        unique case (next_mode)
            PM_NORMAL:
            begin
                next_pwr.core_clk_en = 1'b1;
            end
            PM_IDLE:
            begin
                next_pwr.core_clk_en = 1'b0;
            end
            PM_SUSPEND:
            begin
                next_pwr.reg_low_bias   = 1'b0;
                next_pwr.timer_slow_clk = 1'b1;
            end
            PM_SNOOZE:
            begin
                next_pwr.reg_low_bias   = 1'b1;
                next_pwr.timer_slow_clk = 1'b1;
            end
            PM_STOP, PM_SHUTDOWN:
            begin
                next_pwr.power_nets_off = 1'b1;
                next_pwr.pin_hold       = 1'b1;
            end
        endcase
        // fast oscillators only run while peripherals are clocked
        if (next_mode == PM_NORMAL || next_mode == PM_IDLE)
        begin
            next_pwr.fast_osc_a_en = 1'b1;
            next_pwr.fast_osc_b_en = (next_clock_select.src == SRC_FAST_OSC_B);
        end
        next_pwr.slow_osc_en = !next_pwr.power_nets_off;
        if (next_mode == PM_NORMAL || next_mode == PM_IDLE)
        begin
            next_periph_clk = next_periph_en;
        end
        else
        begin
            next_periph_clk = '0;
        end
    end

    // state registers; sys_rst restores every reset default
    always_ff @(posedge CLK)
    begin
        if (sys_rst)
        begin
            mode              <= PM_NORMAL;
            power_control_0   <= 2'b00;
            power_control_1   <= 2'b00;
            regulator_control <= 1'b0;
            clock_select      <= RST_CLOCK_SELECT[5:0];
            periph_en         <= RST_PERIPH_CLK_EN;
            RDATA             <= RST_ZERO;
            PWR               <= '{core_clk_en: 1'b1, fast_osc_a_en: 1'b1,
                                   slow_osc_en: 1'b1, default: 1'b0};
            PERIPH_CLK_EN     <= RST_PERIPH_CLK_EN;
        end
        else
        begin
            mode              <= next_mode;
            power_control_0   <= next_power_control_0;
            power_control_1   <= next_power_control_1;
            regulator_control <= next_regulator_control;
            clock_select      <= next_clock_select;
            periph_en         <= next_periph_en;
            RDATA             <= next_rdata;
            PWR               <= next_pwr;
            PERIPH_CLK_EN     <= next_periph_clk;
        end
    end

    assign CLK_CFG = clock_select;
    assign MODE    = mode;

    // system clock pace; stops whenever the mode gates the peripheral clocks (all modes but normal and idle)
    pmcc_clkdiv pmcc_clkdiv_i (
        .CLK   (CLK),
        .RESET (sys_rst),
        .RUN   (mode == PM_NORMAL || mode == PM_IDLE),
        .CFG   (clock_select),
        .TICK  (SYSTEM_CLOCK_TICK)
    );

endmodule
`default_nettype wire

// ### bench/pmcc_properties.sv
`timescale 1ns/1ns
`default_nettype none
// passive watcher on the top ports; one clock, one reset
module pmcc_properties
    import pmcc_pkg::*;
(
    input wire logic                CLK,
    input wire logic                RESET,
    input wire logic [ADDR_W-1:0]   ADDR,
    input wire logic [DATA_W-1:0]   WDATA,
    input wire logic                WR,
    input wire logic                RD,
    input wire logic [DATA_W-1:0]   RDATA,
    input wire logic                IRQ_PENDING,
    input wire logic [N_WAKE-1:0]   WAKE_IN,
    input wire logic                RESET_PIN_LOW,
    input wire logic                RESET_SOURCE,
    input wire pmcc_pwr_t           PWR,
    input wire logic [N_PERIPH-1:0] PERIPH_CLK_EN,
    input wire pmcc_clk_cfg_t       CLK_CFG,
    input wire logic                SYSTEM_CLOCK_TICK,
    input wire pmcc_mode_t          MODE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);

    // software asks for idle while running
    sequence s_idle_req;
        MODE == PM_NORMAL && WR && ADDR == OFS_POWER_CONTROL_0 && WDATA[1:0] == 2'h1;
    endsequence
    // a timer event or a comparator fall while asleep
    sequence s_sleep_wake;
        (MODE == PM_SUSPEND || MODE == PM_SNOOZE)
            && ($rose(WAKE_IN[W_TIMER4]) || $fell(WAKE_IN[W_CMP0]));
    endsequence

    property p_reset_clk;
        $fell(RESET) |-> CLK_CFG == 6'h0c && MODE == PM_NORMAL && PWR == 8'hd0;
    endproperty
    property p_idle_entry;
        s_idle_req |=> MODE == PM_IDLE;
    endproperty
    property p_idle_wake;
        MODE == PM_IDLE && IRQ_PENDING |-> ##[1:2] MODE == PM_NORMAL;
    endproperty
    property p_idle_pwr;
        MODE == PM_IDLE |-> !PWR.core_clk_en && PWR.fast_osc_a_en;
    endproperty
    property p_sleep_pwr;
        MODE == PM_SUSPEND || MODE == PM_SNOOZE |-> !PWR.core_clk_en && !PWR.fast_osc_a_en
            && !PWR.fast_osc_b_en && PWR.reg_low_bias == (MODE == PM_SNOOZE);
    endproperty
    property p_slow_timer;
        MODE == PM_SUSPEND || MODE == PM_SNOOZE |-> PWR.timer_slow_clk;
    endproperty
    property p_sleep_wake;
        s_sleep_wake |-> ##[1:5] MODE == PM_NORMAL;
    endproperty
    property p_off_pwr;
        MODE == PM_STOP || MODE == PM_SHUTDOWN |-> PWR.power_nets_off && PWR.pin_hold;
    endproperty
    property p_shutdown_hold;
        (MODE == PM_SHUTDOWN && RESET_PIN_LOW) [*3] |=> MODE == PM_SHUTDOWN;
    endproperty
    // one cycle of grace after a mode change, though the enables are registered from the next mode and switch with it
    property p_periph_gate;
        MODE != PM_NORMAL && MODE != PM_IDLE && $past(MODE) == MODE |-> PERIPH_CLK_EN == 8'h00;
    endproperty

    a_reset_clk: assert property (p_reset_clk) else $error("reset clock setup wrong");
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");
    a_idle_wake: assert property (p_idle_wake) else $error("idle not left on irq");
    a_idle_pwr: assert property (p_idle_pwr) else $error("idle power wrong");
    a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep power wrong");
    a_slow_timer: assert property (p_slow_timer) else $error("timer clock off");
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not left");
    a_off_pwr: assert property (p_off_pwr) else $error("power nets not off");
    a_shutdown_hold: assert property (p_shutdown_hold) else $error("shutdown left");
    a_periph_gate: assert property (p_periph_gate) else $error("periph clock on");
endmodule

bind pmcc_top pmcc_properties pmcc_properties_i (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ_PENDING(IRQ_PENDING),
    .WAKE_IN(WAKE_IN), .RESET_PIN_LOW(RESET_PIN_LOW), .RESET_SOURCE(RESET_SOURCE),
    .PWR(PWR), .PERIPH_CLK_EN(PERIPH_CLK_EN), .CLK_CFG(CLK_CFG),
    .SYSTEM_CLOCK_TICK(SYSTEM_CLOCK_TICK), .MODE(MODE));
`default_nettype wire

// ### bench/pmcc_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module pmcc_top_bench;
    import pmcc_pkg::*;
    logic                clk, reset, wr_s, rd_s, irq, pin_low, rsrc, tick;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata, rdata;
    logic [N_WAKE-1:0]   wake_in;
    logic [N_PERIPH-1:0] periph;
    pmcc_pwr_t           pwr;
    pmcc_clk_cfg_t       clk_cfg;
    pmcc_mode_t          mode;
    int                  n_errors, compares, n;

    pmcc_top pmcc_top_i (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
        .RD(rd_s), .RDATA(rdata), .IRQ_PENDING(irq), .WAKE_IN(wake_in),
        .RESET_PIN_LOW(pin_low), .RESET_SOURCE(rsrc), .PWR(pwr), .PERIPH_CLK_EN(periph),
        .CLK_CFG(clk_cfg), .SYSTEM_CLOCK_TICK(tick), .MODE(mode));

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe; returns just after the edge that takes it
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(16'(rdata), 16'(exp));
    endtask

    // bounded wait, the compare after it catches a hang
    task automatic wait_mode(input pmcc_mode_t m);
        for (int i = 0; i < 12 && mode !== m; i++)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    // cycles spanned by two tick periods (first to third tick), after a settling pass
    task automatic tick_span(output int c);
        int k;
        for (int j = 0; j < 2; j++)
        begin
            c = 0;
            k = 0;
            while (k < 3 && c < 1000)
            begin
                @(posedge clk);
                #1;
                if (tick === 1'b1)
                    k++;
                if (k > 0)
                    c++;
            end
        end
        c = c - 1;
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog sized well past the expected run
    initial
    begin
        repeat (30000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial
    begin
        {reset, wr_s, rd_s, irq, rsrc, addr, wdata} = '1;
        {wr_s, rd_s, irq, rsrc, addr, wdata} = '0;
        pin_low = 1'b1;
        wake_in = 6'h10;   // comparator idles high, its fall wakes
        n_errors = 0;
        compares = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(16'(pwr), 16'h00d0);
        chk(16'(periph), 16'h0000);
        rd_chk(OFS_CLOCK_SELECT, RST_CLOCK_SELECT);
        rd_chk(OFS_MODE_STATUS, 8'h00);
        rd_chk(3'h7, 8'h00);
        tick_span(n);
        chk(16'(n), 16'd16);
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_CLOCK_SELECT, 8'(s));
            chk(16'(clk_cfg.src), 16'(s));
            @(posedge clk);
            #1;
            chk(16'(pwr.fast_osc_b_en), 16'(s == 1));
        end
        for (int d = 0; d < 8; d++)
        begin
            wr(OFS_CLOCK_SELECT, 8'(d << 2));
            tick_span(n);
            chk(16'(n), 16'(2 << d));
        end
        for (int p = 0; p < 4; p++)
        begin
            wr(OFS_CLOCK_SELECT, 8'h20 | 8'(p % 2) | 8'((p / 2) * 12));
            tick_span(n);
            chk(16'(n), 16'(3 << ((p / 2) * 3)));
        end
        wr(OFS_PERIPH_CLK_EN, 8'ha5);
        repeat (2) @(posedge clk);
        #1;
        chk(16'(periph), 16'h00a5);
        chk(16'(pwr.core_clk_en), 16'h0001);
        wr(OFS_CLOCK_SELECT, 8'h00);
        // idle, with a write that must be refused meanwhile
        wr(OFS_POWER_CONTROL_0, 8'h01);
        chk(16'(mode), 16'(PM_IDLE));
        wr(OFS_CLOCK_SELECT, 8'h03);
        chk(16'(periph), 16'h00a5);
        chk(16'(pwr.core_clk_en), 16'h0000);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        wait_mode(PM_NORMAL);
        chk(16'(mode), 16'(PM_NORMAL));
        rd_chk(OFS_POWER_CONTROL_0, 8'h00);
        rd_chk(OFS_CLOCK_SELECT, 8'h00);
        // every wake source against both sleep modes
        for (int m = 0; m < 2; m++)
            for (int w = 0; w < N_WAKE; w++)
            begin
                wr(OFS_POWER_CONTROL_1, 8'(1 << m));
                chk(16'(mode), 16'(m ? PM_SNOOZE : PM_SUSPEND));
                chk(16'(pwr.reg_low_bias), 16'(m));
                chk(16'(pwr.timer_slow_clk), 16'h0001);
                repeat (4) @(posedge clk);
                #1;
                chk(16'(periph), 16'h0000);
                chk(16'(mode), 16'(m ? PM_SNOOZE : PM_SUSPEND));
                @(posedge clk);
                wake_in[w] <= ~wake_in[w];
                wait_mode(PM_NORMAL);
                chk(16'(mode), 16'(PM_NORMAL));
                rd_chk(OFS_POWER_CONTROL_1, 8'h00);
                @(posedge clk);
                wake_in <= 6'h10;
                repeat (4) @(posedge clk);
            end
        // stop, left by a watchdog-type reset
        wr(OFS_REGULATOR_CTRL, 8'h00);
        wr(OFS_POWER_CONTROL_0, 8'h02);
        chk(16'(mode), 16'(PM_STOP));
        chk(16'({pwr.power_nets_off, pwr.pin_hold}), 16'h0003);
        rsrc <= 1'b1;
        repeat (3) @(posedge clk);
        rsrc <= 1'b0;
        wait_mode(PM_NORMAL);
        chk(16'(mode), 16'(PM_NORMAL));
        repeat (4) @(posedge clk);
        rd_chk(OFS_CLOCK_SELECT, RST_CLOCK_SELECT);
        // shutdown ignores that reset, obeys the pin
        wr(OFS_REGULATOR_CTRL, 8'h01);
        wr(OFS_POWER_CONTROL_0, 8'h02);
        chk(16'(mode), 16'(PM_SHUTDOWN));
        chk(16'(pwr.power_nets_off), 16'h0001);
        rsrc <= 1'b1;
        repeat (3) @(posedge clk);
        rsrc <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(16'(mode), 16'(PM_SHUTDOWN));
        pin_low <= 1'b0;
        repeat (3) @(posedge clk);
        pin_low <= 1'b1;
        wait_mode(PM_NORMAL);
        chk(16'(mode), 16'(PM_NORMAL));
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule
`default_nettype wire
